// File: dv/region_memory_protection_test.sv
// self-checking bench of the protection unit and its controller
`default_nettype none
module region_memory_protection_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rmp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic aw = 1'b0, wv = 1'b0, bready = 1'b0, ar = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, grant, fault;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ac_v = 1'b0, ac_f = 1'b0, ac_w = 1'b0, ac_p = 1'b0, ac_h = 1'b0;
  logic [31:0] ac_a = 32'h0;
  logic [31:0] sb [8] = '{default: 32'h0};
  logic [31:0] sa [8] = '{default: 32'h0};
  logic [2:0] aps [6] = '{AP_NONE, AP_PRW_UNO, AP_PRW_URO, AP_PRW_URW, AP_PRO_UNO, AP_PRO_URO};
  logic gon = 1'b0;
  logic [1:0] opt = 2'h0;
  integer seed = 32'ha97e;
  int errors = 0;
  int compares = 0;
  // 100 MHz core clock
  always #5 clk = ~clk;
  rmp_if u_rmp_if ();
  rmp_prot u_rmp_prot (.i_core_clk(clk), .i_reset(rst), .cfg(u_rmp_if), .i_acc_valid(ac_v), .i_acc_addr(ac_a),
    .i_acc_fetch(ac_f), .i_acc_write(ac_w), .i_acc_priv(ac_p), .i_acc_handler(ac_h), .o_acc_grant(grant),
    .o_acc_fault(fault));
  rmp_ctl u_rmp_ctl (.i_core_clk(clk), .i_reset(rst), .cfg(u_rmp_if), .i_awvalid(aw), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(ar), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
  rmp_asserts u_rmp_asserts (.i_core_clk(clk), .i_reset(rst), .valid(u_rmp_if.valid), .op(u_rmp_if.op),
    .region(u_rmp_if.region), .attr(u_rmp_if.attr), .ack(u_rmp_if.ack), .rd_attr(u_rmp_if.rd_attr),
    .i_acc_valid(ac_v), .i_acc_priv(ac_p), .i_acc_handler(ac_h), .o_acc_grant(grant), .o_acc_fault(fault));
  // verdict and end of run
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // compare one result
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one register write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    aw <= 1'b1;
    wv <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awready) aw <= 1'b0;
      if (wready) wv <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk(bresp, er);
    if (!bvalid) chk(32'h0, 32'h1);
    if (!bvalid) summarize();
  endtask
  // one register read
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clk);
    ar <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arready) ar <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    d = rdata;
    chk(rresp, er);
    if (!rvalid) chk(32'h0, 32'h1);
    if (!rvalid) summarize();
  endtask
  // issue a command, wait until idle, mirror its effect
  task automatic cmd(input rmp_op_t o, input logic [2:0] r, input logic [31:0] a, input logic [31:0] t);
    logic [31:0] s;
    int n;
    wr(REG_ADDR, a, RESP_OKAY);
    wr(REG_ATTR, t, RESP_OKAY);
    wr(REG_CMD, {25'h0, r, 1'b0, o}, RESP_OKAY);
    n = 0;
    do begin
      rd(REG_STATUS, RESP_OKAY, s);
      n++;
    end while (s[0] && n < 20);
    if (s[0]) chk(s, 32'h0);
    if (s[0]) summarize();
    case (o)
      op_region_program: begin
        sb[r] = a;
        sa[r] = t;
      end
      op_region_on: sa[r][0] = 1'b1;
      op_region_off: sa[r][0] = 1'b0;
      op_global_protect_on: begin
        gon = 1'b1;
        opt = t[1:0];
      end
      op_global_protect_off: gon = 1'b0;
      default: ;
    endcase
  endtask
  // read a region back and compare with what was set
  task automatic rback(input logic [2:0] r);
    logic [31:0] d;
    cmd(op_region_readback, r, 32'h0, 32'h0);
    rd(REG_RD_ADDR, RESP_OKAY, d);
    chk(d, sb[r]);
    rd(REG_RD_ATTR, RESP_OKAY, d);
    chk(d, sa[r]);
  endtask
  // expected fault of one access under the mirrored settings
  function automatic logic expf(input logic [31:0] a, input logic f, input logic w, input logic p, input logic h);
    logic hit;
    logic xn;
    logic [2:0] ap;
    int n;
    hit = 1'b0;
    xn = 1'b0;
    ap = AP_NONE;
    if (!gon || (h && !opt[1])) return 1'b0;
    for (int r = 0; r < 8; r++) begin
      n = sa[r][5:1];
      if (sa[r][0] && ((a ^ sb[r]) >> (n + 1)) == 0 && !(n >= 7 && sa[r][16 + ((a >> (n - 2)) & 7)])) begin
        hit = 1'b1;
        ap = sa[r][10:8];
        xn = sa[r][12];
      end
    end
    if (!hit) return !(p && opt[0]);
    if (w) return !(p ? ap inside {AP_PRW_UNO, AP_PRW_URO, AP_PRW_URW} : ap == AP_PRW_URW);
    return (f && xn) || !(ap inside {AP_PRW_URO, AP_PRW_URW, AP_PRO_URO} || (p && ap inside {AP_PRW_UNO, AP_PRO_UNO}));
  endfunction
  // random accesses back to back, each answer checked a cycle later
  task automatic burst(input int cnt);
    logic q[$];
    logic e, f, w, p, h;
    logic [31:0] a;
    for (int i = 0; i < cnt + 2; i++) begin
      @(posedge clk);
      if (q.size() == 2 || i > cnt) begin
        e = q.pop_front();
        chk({30'h0, grant, fault}, {30'h0, !e, e});
      end
      {f, w, p, h} = 4'($random(seed));
      w = w & !f;
      a = 32'h2000_0000 | ($random(seed) & 32'h1fff);
      ac_v <= (i < cnt);
      ac_a <= a;
      ac_f <= f;
      ac_w <= w;
      ac_p <= p;
      ac_h <= h;
      if (i < cnt) q.push_back(expf(a, f, w, p, h));
    end
  endtask
  // main sequence
  initial begin
    logic [31:0] d, b, t;
    logic [4:0] sz;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cmd(op_region_count_query, 3'h0, 32'h0, 32'h0);
    rd(REG_RD_ATTR, RESP_OKAY, d);
    chk(d, RMP_REGIONS);
    rd(REG_CMD, RESP_OKAY, d);
    chk(d, 32'(op_region_count_query));
    rd(8'h40, RESP_SLVERR, d);
    chk(d, 32'h0);
    wr(8'h44, 32'h1, RESP_SLVERR);
    // an unused command code is acked and changes nothing
    cmd(rmp_op_t'(3'h7), 3'h5, 32'h1234_5678, 32'h0000_0001);
    rback(3'h5);
    for (int o = 0; o < 4; o++) begin
      cmd(op_global_protect_on, 3'h0, 32'h0, 32'(o));
      burst(24);
    end
    for (int k = 0; k < 6; k++) begin
      cmd(op_global_protect_off, 3'h0, 32'h0, 32'h0);
      for (int r = 0; r < 8; r++) begin
        sz = 5'(4 + $unsigned($random(seed)) % 9);
        if (k == 1 && r == 0) sz = 5'h1f;
        b = (32'h2000_0000 | ($random(seed) & 32'h1fff)) & ~32'((33'h1 << (sz + 6'h1)) - 33'h1);
        t = {8'h0, 8'($random(seed)), 3'h0, 1'($random(seed)), 1'b0, aps[$unsigned($random(seed)) % 6], 2'h0, sz,
          1'($random(seed))};
        // one region stays on at enable
        if (r == 0) t[0] = 1'b1;
        cmd(op_region_program, 3'(r), b, t);
      end
      cmd(op_global_protect_on, 3'h0, 32'h0, 32'($random(seed) & 3));
      burst(60);
      t = 32'($unsigned($random(seed)) % 8);
      cmd(op_region_off, 3'(t), 32'h0, 32'h0);
      rback(3'(t));
      burst(20);
      cmd(op_region_on, 3'(t), 32'h0, 32'h0);
      rback(3'(t));
      burst(20);
    end
    cmd(op_global_protect_off, 3'h0, 32'h0, 32'h0);
    burst(30);
    summarize();
  end
endmodule
`default_nettype wire

// File: dv/rmp_asserts.sv
// checker of the config link and the access answers
`default_nettype none
module rmp_asserts (
  input wire logic i_core_clk, // core clock
  input wire logic i_reset, // reset, high
  input wire logic valid, // command pending
  input wire rmp_pkg::rmp_op_t op, // command code
  input wire logic [2:0] region, // region index
  input wire logic [31:0] attr, // attribute or options
  input wire logic ack, // command done
  input wire logic [31:0] rd_attr, // readback attribute
  input wire logic i_acc_valid, // access offered
  input wire logic i_acc_priv, // privileged access
  input wire logic i_acc_handler, // handler running
  input wire logic o_acc_grant, // access allowed
  input wire logic o_acc_fault // access faulted
);
  timeunit 1ns;
  timeprecision 1ps;
  import rmp_pkg::*;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  typedef struct packed {logic on; logic [1:0] opt; logic [7:0] ena;} rmp_chk_t;
  rmp_chk_t st;
  rmp_chk_t next_st;
  // settings in force at this edge, a command counts from its ack
  always_comb begin
    next_st = st;
    if (ack && op == op_global_protect_on) begin
      next_st.on = 1'b1;
      next_st.opt = attr[1:0];
    end
    if (ack && op == op_global_protect_off) next_st.on = 1'b0;
    if (ack && op == op_region_program) next_st.ena[region] = attr[0];
    if (ack && op == op_region_on) next_st.ena[region] = 1'b1;
    if (ack && op == op_region_off) next_st.ena[region] = 1'b0;
    if (i_reset) next_st = '0;
  end
  // register the tracked settings
  always_ff @(posedge i_core_clk) st <= next_st;
  a_one_answer: assert property (i_acc_valid |=> o_acc_grant != o_acc_fault)
    else $error("access not answered once");
  a_idle_quiet: assert property (!i_acc_valid |=> !o_acc_grant && !o_acc_fault)
    else $error("answer without access");
  a_off_grants: assert property (i_acc_valid && !next_st.on |=> o_acc_grant)
    else $error("fault while unit off");
  a_handler_free: assert property (i_acc_valid && i_acc_handler && !next_st.opt[1] |=> o_acc_grant)
    else $error("handler access checked");
  a_empty_faults: assert property (i_acc_valid && next_st.on && next_st.ena == 8'h0 && !next_st.opt[0]
    && !(i_acc_handler && !next_st.opt[1]) |=> o_acc_fault) else $error("empty map granted");
  a_user_no_map: assert property (i_acc_valid && next_st.on && next_st.ena == 8'h0 && !i_acc_priv
    && !(i_acc_handler && !next_st.opt[1]) |=> o_acc_fault) else $error("user used default map");
  a_ack_timely: assert property ($rose(valid) |=> ack)
    else $error("command not acked");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than a cycle");
  a_count_fixed: assert property (ack && op == op_region_count_query |=> rd_attr == 32'(RMP_REGIONS))
    else $error("wrong region count");
  c_fault: cover property (o_acc_fault);
  c_handler: cover property (i_acc_valid && i_acc_handler && next_st.on);
  c_count: cover property (ack && op == op_region_count_query);
endmodule
`default_nettype wire

// File: logic/rmp_ctl.sv
// protection controller: axi4-lite register slave driving the configuration link
`default_nettype none
module rmp_ctl (
  input wire logic i_core_clk, // core clock
  input wire logic i_reset, // synchronous reset, high
  rmp_if.ctl cfg, // configuration link
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [7:0] i_awaddr, // write address
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // byte enables
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  output logic [1:0] o_bresp, // write response
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  input wire logic [7:0] i_araddr, // read address
  output logic o_rvalid, // read data valid
  input wire logic i_rready, // read data ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp // read response
);
  import rmp_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] addr;
    logic [31:0] attr;
    logic busy;
    rmp_op_t op;
    logic [2:0] region;
    logic [31:0] rd_addr;
    logic [31:0] rd_attr;
  } rmp_ctl_state_t;

  localparam rmp_ctl_state_t RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, op: op_region_program,
                                     default: '0};

  rmp_ctl_state_t q;
  rmp_ctl_state_t next_q;
  logic aw_have;
  logic w_have;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_q = q;
    aw_have = q.aw_got || (i_awvalid && q.awready);
    w_have = q.w_got || (i_wvalid && q.wready);
    wa = q.aw_got ? q.waddr : i_awaddr;
    wd = q.w_got ? q.wdata : i_wdata;
    ws = q.w_got ? q.wstrb : i_wstrb;
    // write channels taken in either order
    if (i_awvalid && q.awready) begin
      next_q.awready = 1'b0;
      next_q.aw_got = 1'b1;
      next_q.waddr = i_awaddr;
    end
    if (i_wvalid && q.wready) begin
      next_q.wready = 1'b0;
      next_q.w_got = 1'b1;
      next_q.wdata = i_wdata;
      next_q.wstrb = i_wstrb;
    end
    // finish the command handshake and keep readback results
    if (q.busy && cfg.ack) begin
      next_q.busy = 1'b0;
      if (q.op == op_region_readback || q.op == op_region_count_query) begin
        next_q.rd_addr = cfg.rd_addr;
        next_q.rd_attr = cfg.rd_attr;
      end
    end
    // perform the write once address and data are both held
    if (aw_have && w_have && !q.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      case (wa)
        REG_CMD: begin
          // a command while one is pending is dropped
          if (ws[0] && !q.busy) begin
            next_q.busy = 1'b1;
            next_q.op = rmp_op_t'(wd[2:0]);
            next_q.region = wd[CMD_REGION_LSB +: 3];
          end
        end
        REG_ADDR: begin
          next_q.addr = merge(q.addr, wd, ws);
        end
        REG_ATTR: begin
          next_q.attr = merge(q.attr, wd, ws);
        end
        REG_STATUS, REG_RD_ADDR, REG_RD_ATTR: begin
          next_q.bresp = RESP_OKAY;
        end
        default: begin
          next_q.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && i_bready) begin
      next_q.bvalid = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end
    // read channel
    if (i_arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OKAY;
      case (i_araddr)
        REG_CMD: next_q.rdata = {25'h0000000, q.region, 1'b0, 3'(q.op)};
        REG_ADDR: next_q.rdata = q.addr;
        REG_ATTR: next_q.rdata = q.attr;
        REG_STATUS: next_q.rdata = {31'h00000000, q.busy};
        REG_RD_ADDR: next_q.rdata = q.rd_addr;
        REG_RD_ATTR: next_q.rdata = q.rd_attr;
        default: begin
          next_q.rdata = 32'h00000000;
          next_q.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && i_rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  assign o_awready = q.awready;
  assign o_wready = q.wready;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_arready = q.arready;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign cfg.valid = q.busy;
  assign cfg.op = q.op;
  assign cfg.region = q.region;
  assign cfg.addr = q.addr;
  assign cfg.attr = q.attr;
endmodule
`default_nettype wire

// File: logic/rmp_if.sv
// configuration link between the protection unit and its controller
`default_nettype none
interface rmp_if;
  import rmp_pkg::*;
  logic valid;
  rmp_op_t op;
  logic [2:0] region;
  logic [31:0] addr;
  logic [31:0] attr;
  logic ack;
  logic [31:0] rd_addr;
  logic [31:0] rd_attr;
  modport dev(input valid, op, region, addr, attr, output ack, rd_addr, rd_attr);
  modport ctl(output valid, op, region, addr, attr, input ack, rd_addr, rd_attr);
endinterface
`default_nettype wire

// File: logic/rmp_pkg.sv
// constants, field layout and command codes of the region memory protection pair
`default_nettype none
package rmp_pkg;
  localparam int RMP_REGIONS = 8;
  // attribute word layout
  localparam int ATTR_ENA_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_AP_LSB = 8;
  localparam int ATTR_XN_BIT = 12;
  localparam int ATTR_SRD_LSB = 16;
  // size code n gives a region of 2^(n+1) bytes
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [4:0] SIZE_SUB_MIN = 5'h07;
  // data permission codes
  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRW_UNO = 3'h1;
  localparam logic [2:0] AP_PRW_URO = 3'h2;
  localparam logic [2:0] AP_PRW_URW = 3'h3;
  localparam logic [2:0] AP_PRO_UNO = 3'h5;
  localparam logic [2:0] AP_PRO_URO = 3'h6;
  // global option bits carried in the attribute field of the enable command
  localparam int OPT_PRIV_MAP_BIT = 0;
  localparam int OPT_FAULT_PROT_BIT = 1;
  // software register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_ATTR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RD_ADDR = 8'h10;
  localparam logic [7:0] REG_RD_ATTR = 8'h14;
  localparam int CMD_REGION_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // configuration commands
  typedef enum logic [2:0] {
    op_region_program,
    op_region_readback,
    op_region_on,
    op_region_off,
    op_global_protect_on,
    op_global_protect_off,
    op_region_count_query
  } rmp_op_t;
endpackage
`default_nettype wire

// File: logic/rmp_prot.sv
// region memory protection unit: region store and per-access check
`default_nettype none
module rmp_prot #(
  parameter int NREG = rmp_pkg::RMP_REGIONS
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_reset, // synchronous reset, high
  rmp_if.dev cfg, // configuration link
  input wire logic i_acc_valid, // access offered this cycle
  input wire logic [31:0] i_acc_addr, // access address
  input wire logic i_acc_fetch, // instruction fetch
  input wire logic i_acc_write, // data write
  input wire logic i_acc_priv, // privileged mode
  input wire logic i_acc_handler, // hard fault or nmi handler running
  output logic o_acc_grant, // access may complete, pulse
  output logic o_acc_fault // memory management fault, pulse
);
  import rmp_pkg::*;

  if (NREG < 1 || NREG > 8) begin : g_bad
    $error("region count must lie in 1..8");
  end

  typedef struct packed {
    logic [NREG-1:0][31:0] base;
    logic [NREG-1:0][31:0] attr;
    logic glob_on;
    logic priv_map;
    logic fault_prot;
    logic ack;
    logic [31:0] rd_addr;
    logic [31:0] rd_attr;
    logic grant;
    logic fault;
  } rmp_dev_state_t;

  localparam rmp_dev_state_t RST = '0;

  rmp_dev_state_t q;
  rmp_dev_state_t next_q;
  logic [NREG-1:0] hit;
  logic any_hit;
  logic [2:0] sel;
  logic [2:0] ap;
  logic xn;
  logic rd_ok;
  logic wr_ok;
  logic viol;
  logic reg_ok;

  // per-region address match
  for (genvar g = 0; g < NREG; g++) begin : g_rgn
    logic [4:0] raw;
    logic [4:0] sz;
    logic [31:0] lowm;
    logic [2:0] sub;
    logic sub_off;
    assign raw = q.attr[g][ATTR_SIZE_LSB +: 5];
    assign sz = (raw < SIZE_MIN) ? SIZE_MIN : raw;
    assign lowm = ~(32'hffffffff << ({1'b0, sz} + 6'h01));
    assign sub = 3'(i_acc_addr >> (sz - 5'h02));
    assign sub_off = (sz >= SIZE_SUB_MIN) && q.attr[g][ATTR_SRD_LSB + sub];
    assign hit[g] = q.attr[g][ATTR_ENA_BIT] && (((i_acc_addr ^ q.base[g]) & ~lowm) == 32'h00000000) &&
                    !sub_off;
  end

  // pick the winning region and judge the access
  always_comb begin
    any_hit = 1'b0;
    sel = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        sel = 3'(i);
      end
    end
    ap = q.attr[sel][ATTR_AP_LSB +: 3];
    xn = q.attr[sel][ATTR_XN_BIT];
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (ap)
      AP_PRW_UNO: begin
        rd_ok = i_acc_priv;
        wr_ok = i_acc_priv;
      end
      AP_PRW_URO: begin
        rd_ok = 1'b1;
        wr_ok = i_acc_priv;
      end
      AP_PRW_URW: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      AP_PRO_UNO: begin
        rd_ok = i_acc_priv;
      end
      AP_PRO_URO: begin
        rd_ok = 1'b1;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    if (!q.glob_on) begin
      viol = 1'b0;
    end else if (i_acc_handler && !q.fault_prot) begin
      viol = 1'b0;
    end else if (any_hit) begin
      if (i_acc_fetch) begin
        viol = xn || !rd_ok;
      end else begin
        viol = i_acc_write ? !wr_ok : !rd_ok;
      end
    end else if (i_acc_priv && q.priv_map) begin
      viol = 1'b0;
    end else begin
      viol = 1'b1;
    end
  end

  // next state: access answer and configuration commands
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.grant = 1'b0;
    next_q.fault = 1'b0;
    reg_ok = 32'(cfg.region) < NREG;
    if (i_acc_valid) begin
      next_q.fault = viol;
      next_q.grant = !viol;
    end
    if (cfg.valid && !q.ack) begin
      next_q.ack = 1'b1;
      case (cfg.op)
        op_region_program: begin
          if (reg_ok) begin
            next_q.base[cfg.region] = cfg.addr;
            next_q.attr[cfg.region] = cfg.attr;
          end
        end
        op_region_readback: begin
          next_q.rd_addr = reg_ok ? q.base[cfg.region] : 32'h00000000;
          next_q.rd_attr = reg_ok ? q.attr[cfg.region] : 32'h00000000;
        end
        op_region_on: begin
          if (reg_ok) begin
            next_q.attr[cfg.region][ATTR_ENA_BIT] = 1'b1;
          end
        end
        op_region_off: begin
          if (reg_ok) begin
            next_q.attr[cfg.region][ATTR_ENA_BIT] = 1'b0;
          end
        end
        op_global_protect_on: begin
          next_q.glob_on = 1'b1;
          next_q.priv_map = cfg.attr[OPT_PRIV_MAP_BIT];
          next_q.fault_prot = cfg.attr[OPT_FAULT_PROT_BIT];
        end
        op_global_protect_off: begin
          next_q.glob_on = 1'b0;
        end
        op_region_count_query: begin
          next_q.rd_addr = 32'h00000000;
          next_q.rd_attr = 32'(NREG);
        end
        default: begin
          next_q.ack = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  assign o_acc_grant = q.grant;
  assign o_acc_fault = q.fault;
  assign cfg.ack = q.ack;
  assign cfg.rd_addr = q.rd_addr;
  assign cfg.rd_attr = q.rd_attr;
endmodule
`default_nettype wire
